// [design/cdx_codec.sv]
// 8b/10b encoder and decoder with running disparity on each side
// assumes: host and line words move one per i_mclk; fifo on the send path
`timescale 1ns/1ps
`include "cdx_defs.svh"

module cdx_codec #(
	parameter int FIFO_DEPTH = `CDX_FIFO_D
) (
	input  wire logic                   i_mclk,
	input  wire logic                   i_nrst,
	input  wire logic                   i_tx_valid,
	input  wire logic [`CDX_BYTE_W-1:0] i_tx_byte,
	input  wire logic                   i_tx_special,
	output wire logic                   o_tx_ready,
	input  wire logic                   i_tx_line_ready,
	output wire logic                   o_tx_char_valid,
	output wire logic [`CDX_CHAR_W-1:0] o_tx_char,
	output wire logic                   o_tx_rd,
	input  wire logic                   i_rx_char_valid,
	input  wire logic [`CDX_CHAR_W-1:0] i_rx_char,
	output wire logic                   o_rx_valid,
	output wire logic [`CDX_BYTE_W-1:0] o_rx_byte,
	output wire logic                   o_rx_special,
	output wire logic                   o_rx_violation,
	output wire logic                   o_rx_rd
);

	// ------------------------------------------------------------------
	// code tables, current rd negative column
	// ------------------------------------------------------------------
	function automatic logic [5:0] tab6(input logic [4:0] x);
		logic [5:0] t;
		t = 6'h00;
		unique case (x)
			5'h00: t = 6'h27;
			5'h01: t = 6'h1d;
			5'h02: t = 6'h2d;
			5'h03: t = 6'h31;
			5'h04: t = 6'h35;
			5'h05: t = 6'h29;
			5'h06: t = 6'h19;
			5'h07: t = 6'h38;
			5'h08: t = 6'h39;
			5'h09: t = 6'h25;
			5'h0a: t = 6'h15;
			5'h0b: t = 6'h34;
			5'h0c: t = 6'h0d;
			5'h0d: t = 6'h2c;
			5'h0e: t = 6'h1c;
			5'h0f: t = 6'h17;
			5'h10: t = 6'h1b;
			5'h11: t = 6'h23;
			5'h12: t = 6'h13;
			5'h13: t = 6'h32;
			5'h14: t = 6'h0b;
			5'h15: t = 6'h2a;
			5'h16: t = 6'h1a;
			5'h17: t = 6'h3a;
			5'h18: t = 6'h33;
			5'h19: t = 6'h26;
			5'h1a: t = 6'h16;
			5'h1b: t = 6'h36;
			5'h1c: t = 6'h0e;
			5'h1d: t = 6'h2e;
			5'h1e: t = 6'h1e;
			5'h1f: t = 6'h2b;
		endcase
		return t;
	endfunction

	function automatic logic [3:0] tab4(input logic [2:0] y);
		logic [3:0] t;
		t = 4'h0;
		unique case (y)
			3'h0: t = 4'hb;
			3'h1: t = 4'h9;
			3'h2: t = 4'h5;
			3'h3: t = 4'hc;
			3'h4: t = 4'hd;
			3'h5: t = 4'ha;
			3'h6: t = 4'h6;
			3'h7: t = 4'he;
		endcase
		return t;
	endfunction

	// ------------------------------------------------------------------
	// sub-block disparity
	// ------------------------------------------------------------------
	function automatic logic rd6(input logic [5:0] s, input logic rd);
		logic [2:0] n;
		logic       r;
		n = 3'($countones(s));
		r = rd;
		if (n > `CDX_HALF6 || s == `CDX_S6_POS) begin
			r = `CDX_RD_POS;
		end else if (n < `CDX_HALF6 || s == `CDX_S6_NEG) begin
			r = `CDX_RD_NEG;
		end
		return r;
	endfunction

	function automatic logic rd4(input logic [3:0] s, input logic rd);
		logic [2:0] n;
		logic       r;
		n = 3'($countones(s));
		r = rd;
		if (n > `CDX_HALF4 || s == `CDX_S4_POS) begin
			r = `CDX_RD_POS;
		end else if (n < `CDX_HALF4 || s == `CDX_S4_NEG) begin
			r = `CDX_RD_NEG;
		end
		return r;
	endfunction

	// ending disparity of a whole character, bit 9 = a
	function automatic logic rd10(input logic [9:0] c, input logic rd);
		return rd4(c[3:0], rd6(c[9:4], rd));
	endfunction

	// ------------------------------------------------------------------
	// encoder: returns {ending rd, abcdeifghj}
	// ------------------------------------------------------------------
	function automatic logic [10:0] enc(input logic [7:0] b, input logic k,
	                                    input logic rd);
		logic [4:0] x;
		logic [2:0] y;
		logic       r;
		logic       r6;
		logic       a7;
		logic [5:0] six;
		logic [3:0] four;
		x = b[4:0];
		y = b[7:5];
		r = rd;
		if (k) begin
			x = `CDX_X28;
			y = `CDX_K28_5Y;
			if (b <= `CDX_K_LAST28) begin
				y = b[2:0];
			end else if (b == `CDX_K23_7) begin
				x = `CDX_X23;
				y = `CDX_Y7;
			end else if (b == `CDX_K27_7) begin
				x = `CDX_X27;
				y = `CDX_Y7;
			end else if (b == `CDX_K29_7) begin
				x = `CDX_X29;
				y = `CDX_Y7;
			end else if (b == `CDX_K30_7) begin
				x = `CDX_X30;
				y = `CDX_Y7;
			end else if (b == `CDX_C1_7) begin
				r = `CDX_RD_NEG;
			end else if (b == `CDX_C2_7) begin
				r = `CDX_RD_POS;
			end
		end
		six = (k && x == `CDX_X28) ? `CDX_K28_6B : tab6(x);
		if (r && (($countones(six) != 3) || x == `CDX_X7)) begin
			six = ~six;
		end
		r6 = rd6(six, r);
		a7 = k || (!r && (x == 5'h11 || x == 5'h12 || x == 5'h14))
		       || (r && (x == 5'h0b || x == 5'h0d || x == 5'h0e));
		if (y == `CDX_Y7 && a7) begin
			four = r6 ? `CDX_A7_POS : `CDX_A7_NEG;
		end else begin
			four = tab4(y);
			// special y=3 keeps 1100 after a negative 6-bit block
			if (k && !r6 && ($countones(four) == 2) && y != `CDX_Y3) begin
				four = ~four;
			end else if (r6 && (($countones(four) != 2) || y == `CDX_Y3)) begin
				four = ~four;
			end
		end
		// i closes the 6-bit block, j the 4-bit one
		return {rd4(four, r6), six, four};
	endfunction

	// ------------------------------------------------------------------
	// send path: fifo then encoder stage
	// ------------------------------------------------------------------
	cdx_strm_if #(.W(`CDX_BYTE_W + 1)) s_in ();
	cdx_strm_if #(.W(`CDX_BYTE_W + 1)) s_out ();

	assign s_in.valid = i_tx_valid;
	assign s_in.data  = {i_tx_special, i_tx_byte};
	assign o_tx_ready = s_in.ready;

	cdx_fifo #(
		.W     (`CDX_BYTE_W + 1),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_mclk (i_mclk),
		.i_nrst (i_nrst),
		.wr     (s_in),
		.rd     (s_out)
	);

	cdx_pkg::cdx_top_s st_q;
	cdx_pkg::cdx_top_s st_d;
	logic [10:0]       enc_w;
	logic [10:0]       cand;
	logic [7:0]        cb;
	logic              ck;
	logic              hit;
	logic              wrong;

	assign s_out.ready = !st_q.tx_vld || i_tx_line_ready;
	assign enc_w       = enc(s_out.data[7:0], s_out.data[8], st_q.tx_rd);

	// ------------------------------------------------------------------
	// next state: encoder load and decoder search
	// ------------------------------------------------------------------
	always_comb begin
		st_d  = st_q;
		cand  = '0;
		cb    = '0;
		ck    = 1'b0;
		hit   = 1'b0;
		wrong = 1'b0;
		if (s_out.ready) begin
			st_d.tx_vld = s_out.valid;
			if (s_out.valid) begin
				st_d.tx_chr = enc_w[9:0];
				st_d.tx_rd  = enc_w[10];
			end
		end
		st_d.rx_vld = i_rx_char_valid;
		if (i_rx_char_valid) begin
			st_d.rx_byte = `CDX_C0_7;
			st_d.rx_spec = 1'b1;
			for (int n = 0; n < `CDX_N_DATA + `CDX_N_SPEC; n++) begin
				ck = (n >= `CDX_N_DATA);
				cb = ck ? 8'(n - `CDX_N_DATA) : 8'(n);
				cand = enc(cb, ck, st_q.rx_rd);
				if (!hit && cand[9:0] == i_rx_char) begin
					hit          = 1'b1;
					st_d.rx_byte = cb;
					st_d.rx_spec = ck;
				end
				cand = enc(cb, ck, !st_q.rx_rd);
				if (cand[9:0] == i_rx_char) begin
					wrong = 1'b1;
				end
			end
			if (!hit && wrong) begin
				st_d.rx_byte = `CDX_C4_7;
				st_d.rx_spec = 1'b1;
			end
			st_d.rx_viol = !hit;
			st_d.rx_rd   = rd10(i_rx_char, st_q.rx_rd);
		end
	end

	// ------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_q       <= '0;
			st_q.tx_rd <= `CDX_RD_RST;
			st_q.rx_rd <= `CDX_RD_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_tx_char_valid = st_q.tx_vld;
	assign o_tx_char       = st_q.tx_chr;
	assign o_tx_rd         = st_q.tx_rd;
	assign o_rx_valid      = st_q.rx_vld;
	assign o_rx_byte       = st_q.rx_byte;
	assign o_rx_special    = st_q.rx_spec;
	assign o_rx_violation  = st_q.rx_viol;
	assign o_rx_rd         = st_q.rx_rd;

endmodule

// [design/cdx_defs.svh]
// constants of the 8b/10b codec: widths, code points, disparity patterns
// assumes: included by bare name by the codec top, the fifo and the package
`ifndef CDX_DEFS_SVH
`define CDX_DEFS_SVH

// ------------------------------------------------------------------
// widths and counts
// ------------------------------------------------------------------
`define CDX_BYTE_W   8
`define CDX_CHAR_W   10
`define CDX_FIFO_D   16
`define CDX_N_DATA   256
`define CDX_N_SPEC   12

// ------------------------------------------------------------------
// running disparity
// ------------------------------------------------------------------
`define CDX_RD_NEG   1'b0
`define CDX_RD_POS   1'b1
`define CDX_RD_RST   `CDX_RD_NEG

// ------------------------------------------------------------------
// special character codes on the host side
// ------------------------------------------------------------------
`define CDX_K_LAST28 8'h07
`define CDX_K23_7    8'h08
`define CDX_K27_7    8'h09
`define CDX_K29_7    8'h0a
`define CDX_K30_7    8'h0b
`define CDX_C0_7     8'he0
`define CDX_C1_7     8'he1
`define CDX_C2_7     8'he2
`define CDX_C4_7     8'he4
`define CDX_K28_5Y   3'h5

// ------------------------------------------------------------------
// sub-block values
// ------------------------------------------------------------------
`define CDX_X23      5'h17
`define CDX_X27      5'h1b
`define CDX_X28      5'h1c
`define CDX_X29      5'h1d
`define CDX_X30      5'h1e
`define CDX_X7       5'h07
`define CDX_Y3       3'h3
`define CDX_Y7       3'h7
`define CDX_K28_6B   6'h0f
`define CDX_S6_POS   6'h07
`define CDX_S6_NEG   6'h38
`define CDX_S4_POS   4'h3
`define CDX_S4_NEG   4'hc
`define CDX_A7_NEG   4'h7
`define CDX_A7_POS   4'h8
`define CDX_HALF6    3'h3
`define CDX_HALF4    3'h2

`endif

// [design/cdx_fifo.sv]
// synchronous fifo with valid/ready on both sides
// assumes: DEPTH is a power of two, one clock, async active-low reset
`timescale 1ns/1ps
`include "cdx_defs.svh"

module cdx_fifo #(
	parameter int W     = 9,
	parameter int DEPTH = `CDX_FIFO_D
) (
	input wire logic i_mclk,
	input wire logic i_nrst,
	cdx_strm_if.snk  wr,
	cdx_strm_if.src  rd
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
		logic                    rdy;
	} cdx_fifo_s;

	cdx_fifo_s st_q;
	cdx_fifo_s st_d;
	logic      push;
	logic      pop;

	assign wr.ready = st_q.rdy;
	assign rd.valid = (st_q.cnt != '0);
	assign rd.data  = st_q.mem[st_q.rp];

	always_comb begin
		st_d = st_q;
		push = wr.valid & st_q.rdy;
		pop  = rd.valid & rd.ready;
		if (push) begin
			st_d.mem[st_q.wp] = wr.data;
			st_d.wp           = st_q.wp + AW'(1);
		end
		if (pop) begin
			st_d.rp = st_q.rp + AW'(1);
		end
		st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
		st_d.rdy = (st_d.cnt != (AW+1)'(DEPTH));
	end

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_q     <= '0;
			st_q.rdy <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

endmodule

// [design/cdx_pkg.sv]
// types used by the codec top
// assumes: cdx_defs.svh on the include path
`include "cdx_defs.svh"

package cdx_pkg;

	// ------------------------------------------------------------------
	// state of the codec top
	// ------------------------------------------------------------------
	typedef struct packed {
		logic                     tx_vld;
		logic [`CDX_CHAR_W-1:0]   tx_chr;
		logic                     tx_rd;
		logic                     rx_vld;
		logic [`CDX_BYTE_W-1:0]   rx_byte;
		logic                     rx_spec;
		logic                     rx_viol;
		logic                     rx_rd;
	} cdx_top_s;

endpackage

// [design/cdx_strm_if.sv]
// valid/ready stream between the codec top and its fifo
// assumes: one clock shared by both ends
`timescale 1ns/1ps

interface cdx_strm_if #(
	parameter int W = 9
);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface

// [sim/cdx_codec_asserts.sv]
// concurrent checks on the ports of the codec top
// assumes: bound into cdx_codec, one clock, reset async active low
`timescale 1ns/1ps

module cdx_codec_asserts (
	input wire logic       i_mclk,
	input wire logic       i_nrst,
	input wire logic       i_tx_line_ready,
	input wire logic       o_tx_char_valid,
	input wire logic [9:0] o_tx_char,
	input wire logic       o_tx_rd,
	input wire logic       i_rx_char_valid,
	input wire logic [9:0] i_rx_char,
	input wire logic       o_rx_valid,
	input wire logic [7:0] o_rx_byte,
	input wire logic       o_rx_special,
	input wire logic       o_rx_violation,
	input wire logic       o_rx_rd
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);

	// ------------------------------------------------------------------
	// disparity of a character from its two sub-blocks
	// ------------------------------------------------------------------
	function automatic logic rd6(input logic [5:0] s, input logic r);
		if (s == 6'h07) return 1'b1;
		if (s == 6'h38) return 1'b0;
		if ($countones(s) != 3) return $countones(s) > 3;
		return r;
	endfunction

	function automatic logic rd4(input logic [3:0] s, input logic r);
		if (s == 4'h3) return 1'b1;
		if (s == 4'hc) return 1'b0;
		if ($countones(s) != 2) return $countones(s) > 2;
		return r;
	endfunction

	function automatic logic rd10(input logic [9:0] c, input logic r);
		return rd4(c[3:0], rd6(c[9:4], r));
	endfunction

	sequence s_rx_take;
		i_rx_char_valid;
	endsequence

	// a new character enters the send stage
	sequence s_tx_load;
		(!o_tx_char_valid || i_tx_line_ready) ##1 o_tx_char_valid;
	endsequence

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	a_rx_answer_next: assert property (s_rx_take |=> o_rx_valid)
		else $error("decoded result missing one cycle after a character");
	a_rx_quiet_idle: assert property (!i_rx_char_valid |=> !o_rx_valid && $stable(o_rx_rd))
		else $error("decoder moved without a received character");
	a_rx_rd_bits: assert property (s_rx_take |=> o_rx_rd == rd10($past(i_rx_char), $past(o_rx_rd)))
		else $error("decoder disparity does not follow the received bits");
	a_viol_special: assert property (o_rx_valid && o_rx_violation |-> o_rx_special)
		else $error("violation without special flag");
	a_viol_code: assert property (o_rx_valid && o_rx_violation |-> o_rx_byte inside {8'he0, 8'he4})
		else $error("violation with an unexpected code");
	a_data_clean: assert property (o_rx_valid && !o_rx_special |-> !o_rx_violation)
		else $error("data character flagged as violation");
	a_tx_stall_hold: assert property (o_tx_char_valid && !i_tx_line_ready |=>
		o_tx_char_valid && $stable(o_tx_char) && $stable(o_tx_rd))
		else $error("send character changed while the line stalled");
	a_tx_rd_load: assert property (s_tx_load |-> o_tx_rd == rd10(o_tx_char, $past(o_tx_rd)))
		else $error("encoder disparity does not follow the sent character");
endmodule

bind cdx_codec cdx_codec_asserts u_cdx_codec_asserts (
	.i_mclk(i_mclk), .i_nrst(i_nrst), .i_tx_line_ready(i_tx_line_ready),
	.o_tx_char_valid(o_tx_char_valid), .o_tx_char(o_tx_char), .o_tx_rd(o_tx_rd),
	.i_rx_char_valid(i_rx_char_valid), .i_rx_char(i_rx_char), .o_rx_valid(o_rx_valid),
	.o_rx_byte(o_rx_byte), .o_rx_special(o_rx_special), .o_rx_violation(o_rx_violation),
	.o_rx_rd(o_rx_rd)
);

// [sim/cdx_line_model.sv]
// far end of the send line: takes characters at a chosen pace
// assumes: same clock as the codec; pace inputs change just after the edge
`timescale 1ns/1ps

module cdx_line_model (
	input  wire logic       i_mclk,
	input  wire logic       i_slow,
	input  wire logic       i_hold,
	input  wire logic       i_char_valid,
	input  wire logic [9:0] i_char,
	output wire logic       o_ready
);
	logic       phase_q = 1'b0;
	logic [9:0] got [$];

	// slow takes every other cycle, hold stalls fully
	assign o_ready = !i_hold && (!i_slow || phase_q);

	always @(posedge i_mclk) begin
		phase_q <= ~phase_q;
		// kept whole, bit 9 is a and goes on the line first
		if (i_char_valid && o_ready) got.push_back(i_char);
	end
endmodule

// [sim/tb.sv]
// self-checking bench of the codec: send stream, fifo fill, decode, reset
// assumes: cdx_line_model takes the send line, bench drives the receive side
`timescale 1ns/1ps

module tb;
	logic       i_mclk          = 1'b0;
	logic       i_nrst          = 1'b0;
	logic       i_tx_valid      = 1'b0;
	logic [7:0] i_tx_byte       = 8'h00;
	logic       i_tx_special    = 1'b0;
	logic       i_rx_char_valid = 1'b0;
	logic [9:0] i_rx_char       = 10'h000;
	logic       slow            = 1'b0;
	logic       hold            = 1'b0;
	wire logic  o_tx_ready, i_tx_line_ready, o_tx_char_valid, o_tx_rd;
	wire logic  o_rx_valid, o_rx_special, o_rx_violation, o_rx_rd;
	wire logic [9:0] o_tx_char;
	wire logic [7:0] o_rx_byte;
	int         n_mismatch      = 0;
	int         n_compared      = 0;
	int         cycles          = 0;

	cdx_codec u_cdx_codec (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_tx_valid(i_tx_valid),
		.i_tx_byte(i_tx_byte), .i_tx_special(i_tx_special), .o_tx_ready(o_tx_ready),
		.i_tx_line_ready(i_tx_line_ready), .o_tx_char_valid(o_tx_char_valid),
		.o_tx_char(o_tx_char), .o_tx_rd(o_tx_rd), .i_rx_char_valid(i_rx_char_valid),
		.i_rx_char(i_rx_char), .o_rx_valid(o_rx_valid), .o_rx_byte(o_rx_byte),
		.o_rx_special(o_rx_special), .o_rx_violation(o_rx_violation), .o_rx_rd(o_rx_rd));
	cdx_line_model u_cdx_line_model (.i_mclk(i_mclk), .i_slow(slow), .i_hold(hold),
		.i_char_valid(o_tx_char_valid), .i_char(o_tx_char), .o_ready(i_tx_line_ready));

	initial forever #20 i_mclk = ~i_mclk;

	always @(posedge i_mclk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			n_mismatch = n_mismatch + 1;
			complete_run();
		end
	end

	// ------------------------------------------------------------------
	// compare and report
	// ------------------------------------------------------------------
	task automatic chk_bit(input string what, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %b, seen %b", what, exp, got);
		end
	endtask

	task automatic chk_vec(input string what, input logic [9:0] exp, input logic [9:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic complete_run();
		$display("compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// drivers
	// ------------------------------------------------------------------
	task automatic do_reset();
		i_nrst = 1'b0;
		repeat (5) @(posedge i_mclk);
		#1;
		i_nrst = 1'b1;
	endtask

	task automatic push(input logic [7:0] b, input logic sp);
		logic ok;
		i_tx_byte = b;
		i_tx_special = sp;
		i_tx_valid = 1'b1;
		do begin
			ok = (o_tx_ready === 1'b1);
			@(posedge i_mclk);
			#1;
		end while (!ok);
	endtask

	task automatic wait_got(input int n);
		for (int k = 0; k < 200 && u_cdx_line_model.got.size() < n; k++) begin
			@(posedge i_mclk);
			#1;
		end
	endtask

	task automatic rx(input logic [9:0] c, input logic [7:0] b, input logic sp,
		input logic vi, input logic rd);
		i_rx_char_valid = 1'b1;
		i_rx_char = c;
		@(posedge i_mclk);
		#1;
		i_rx_char_valid = 1'b0;
		i_rx_char = ~c;
		chk_bit("rx valid", 1'b1, o_rx_valid);
		chk_vec("rx byte", {2'h0, b}, {2'h0, o_rx_byte});
		chk_bit("rx special", sp, o_rx_special);
		chk_bit("rx violation", vi, o_rx_violation);
		chk_bit("rx disparity", rd, o_rx_rd);
		@(posedge i_mclk);
		#1;
		chk_bit("rx valid drops", 1'b0, o_rx_valid);
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_stream();
		logic [8:0] bytes [16] = '{9'h045, 9'h1e2, 9'h007, 9'h1e1, 9'h000, 9'h105,
			9'h003, 9'h001, 9'h103, 9'h108, 9'h109, 9'h10a,
			9'h10b, 9'h120, 9'h0eb, 9'h105};
		logic [9:0] chars [16] = '{10'h295, 10'h305, 10'h38b, 10'h0fa, 10'h18b, 10'h305,
			10'h31b, 10'h22b, 10'h30c, 10'h3a8, 10'h368, 10'h2e8,
			10'h1e8, 10'h0fa, 10'h348, 10'h0fa};
		slow = 1'b1;
		u_cdx_line_model.got.delete();
		foreach (bytes[k]) push(bytes[k][7:0], bytes[k][8]);
		i_tx_valid = 1'b0;
		wait_got(16);
		foreach (chars[k]) chk_vec("tx char", chars[k], u_cdx_line_model.got[k]);
		chk_bit("tx disparity", 1'b1, o_tx_rd);
		slow = 1'b0;
	endtask

	task automatic t_fill();
		int n;
		n = 0;
		hold = 1'b1;
		u_cdx_line_model.got.delete();
		i_tx_byte = 8'h45;
		i_tx_special = 1'b0;
		i_tx_valid = 1'b1;
		repeat (24) begin
			if (o_tx_ready === 1'b1) n++;
			@(posedge i_mclk);
			#1;
		end
		i_tx_valid = 1'b0;
		chk_bit("ready when full", 1'b0, o_tx_ready);
		// sixteen fifo entries plus the one character in the send stage
		chk_vec("bytes held when full", 10'h011, 10'(n));
		hold = 1'b0;
		slow = 1'b1;
		wait_got(n);
		@(posedge i_mclk);
		#1;
		chk_vec("drained count", 10'(n), 10'(u_cdx_line_model.got.size()));
		for (int k = 0; k < n; k++) chk_vec("drained char", 10'h295, u_cdx_line_model.got[k]);
		chk_bit("ready when drained", 1'b1, o_tx_ready);
		slow = 1'b0;
	endtask

	task automatic t_rx();
		rx(10'h0fa, 8'h05, 1'b1, 1'b0, 1'b1);
		rx(10'h0fa, 8'he4, 1'b1, 1'b1, 1'b1);
		rx(10'h295, 8'h45, 1'b0, 1'b0, 1'b1);
		rx(10'h000, 8'he0, 1'b1, 1'b1, 1'b0);
		rx(10'h38b, 8'h07, 1'b0, 1'b0, 1'b1);
		rx(10'h074, 8'h07, 1'b0, 1'b0, 1'b0);
		rx(10'h0fa, 8'h05, 1'b1, 1'b0, 1'b1);
		rx(10'h057, 8'h08, 1'b1, 1'b0, 1'b1);
	endtask

	task automatic t_rst();
		do_reset();
		chk_bit("tx disparity after reset", 1'b0, o_tx_rd);
		chk_bit("rx disparity after reset", 1'b0, o_rx_rd);
		chk_bit("ready after reset", 1'b1, o_tx_ready);
		rx(10'h0fa, 8'h05, 1'b1, 1'b0, 1'b1);
	endtask

	initial begin
		do_reset();
		chk_bit("ready out of reset", 1'b1, o_tx_ready);
		chk_bit("char valid out of reset", 1'b0, o_tx_char_valid);
		t_stream();
		t_fill();
		t_rx();
		t_rst();
		complete_run();
	end
endmodule
